// File: core/secp_pkg.sv
// Purpose: Shared constants and types for the serial memory command port
// Assumes: 40 MHz system clock, 17-bit address (largest density)
// Notes: Opcodes live here only; write and erase cycle limits here are defaults that the WriteCycles and EraseCycles parameters override
package secp_pkg;
   // ***************************************************
   // Opcodes
   // ***************************************************
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] PAGE_ERASE_CMD = 8'h42;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
   localparam logic [7:0] CHIP_ERASE_CMD = 8'hC7;
   localparam logic [7:0] WAKE_AND_SIGNATURE_CMD = 8'hAB;
   localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
   // ***************************************************
   // Geometry and timing
   // ***************************************************
   localparam int ADDR_W = 17;
   localparam int ADDR_BYTES = 3;
   localparam int PAGE_W = 8;
   localparam int CLK_HZ = 40000000;
   localparam int WRITE_MS = 6;
   localparam int ERASE_MS = 15;
   localparam int WAKE_US = 100;
   localparam int SLEEP_US = 100;
   localparam int WRITE_CYC = CLK_HZ / 1000 * WRITE_MS;
   localparam int ERASE_CYC = CLK_HZ / 1000 * ERASE_MS;
   localparam int WAKE_CYC = CLK_HZ / 1000000 * WAKE_US;
   localparam int SLEEP_CYC = CLK_HZ / 1000000 * SLEEP_US;
   localparam int CNT_W = 20;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   typedef enum logic [2:0] {
      SECP_OP_NONE = 3'b000,
      SECP_OP_WRITE = 3'b001,
      SECP_OP_STATUS = 3'b010,
      SECP_OP_PAGE_ERASE = 3'b011,
      SECP_OP_SECTOR_ERASE = 3'b100,
      SECP_OP_CHIP_ERASE = 3'b101
   } secp_job_t;

   // Completed command handed from link domain to system domain
   typedef struct packed {
      secp_job_t job;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
      logic [8:0] count;
   } secp_cmd_t;
endpackage

// File: core/secp_port.sv
// Purpose: Serial command front end of a byte-wide nonvolatile memory
// Assumes: Host drives select, clock, data in, pause; link clock stops outside frames
// Notes: Array storage is outside; this block issues array requests
`timescale 1ns/10ps

module secp_port
   import secp_pkg::*;
#(
   parameter int WriteCycles = WRITE_CYC,
   parameter int EraseCycles = ERASE_CYC,
   parameter logic [7:0] SIGNATURE = 8'h5A // Arbitrary value
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic linkClk,
   input wire logic selectN,
   input wire logic serialIn,
   input wire logic pauseN,
   output logic serialOut,
   output logic serialOutEn,
   output logic [ADDR_W-1:0] arrayAddr,
   input wire logic [7:0] arrayRdData,
   output logic [ADDR_W-1:0] memAddr,
   output logic [7:0] memData,
   output logic memWrite,
   output secp_job_t memJob,
   output logic busy,
   output logic writeLatch,
   output logic deepSleep
);
   // ***************************************************
   // Link domain: shifter
   // ***************************************************
   typedef enum logic [1:0] {
      SECP_PH_INSTR = 2'b00,
      SECP_PH_ADDR = 2'b01,
      SECP_PH_DATA = 2'b10,
      SECP_PH_IDLE = 2'b11
   } secp_phase_t;

   // Select acts as asynchronous frame reset of the link logic; clock stops between frames
   secp_phase_t phase, next_phase;
   logic [7:0] shiftReg, next_shiftReg;
   logic [7:0] instr, next_instr;
   logic [2:0] bitCnt, next_bitCnt;
   logic [1:0] addrCnt, next_addrCnt;
   logic [ADDR_W-1:0] addrReg, next_addrReg;
   logic [7:0] outByte, next_outByte;
   logic [8:0] byteCnt, next_byteCnt;
   logic [7:0] firstData, next_firstData;
   logic byteDone, next_byteDone;
   logic [7:0] statusSync;
   logic readBlocked;
   logic paused;

   assign paused = ~pauseN;

   always_comb begin
      next_phase = phase;
      next_shiftReg = {shiftReg[6:0], serialIn};
      next_instr = instr;
      next_bitCnt = bitCnt + 3'h1;
      next_addrCnt = addrCnt;
      next_addrReg = addrReg;
      next_outByte = {outByte[6:0], 1'b0};
      next_byteCnt = byteCnt;
      next_firstData = firstData;
      next_byteDone = 1'b0;
      if (paused) begin
         next_phase = phase;
         next_shiftReg = shiftReg;
         next_bitCnt = bitCnt;
         next_outByte = outByte;
         next_byteDone = byteDone;
      end else if (bitCnt == 3'h7) begin
         unique case (phase)
            SECP_PH_INSTR: begin
               next_instr = {shiftReg[6:0], serialIn};
               next_addrCnt = 2'h0;
               next_byteDone = 1'b1;
               case (next_instr)
                  OP_READ, OP_WRITE, PAGE_ERASE_CMD, SECTOR_ERASE_CMD: next_phase = SECP_PH_ADDR;
                  STATUS_READ_CMD: begin
                     next_phase = SECP_PH_DATA;
                     next_outByte = statusSync;
                  end
                  WAKE_AND_SIGNATURE_CMD: begin
                     next_phase = SECP_PH_DATA;
                     next_outByte = SIGNATURE;
                  end
                  STATUS_WRITE_CMD: next_phase = SECP_PH_DATA;
                  default: next_phase = SECP_PH_IDLE;
               endcase
            end
            SECP_PH_ADDR: begin
               next_addrReg = ADDR_W'({addrReg, shiftReg[6:0], serialIn});
               next_addrCnt = addrCnt + 2'h1;
               if (addrCnt == 2'(ADDR_BYTES - 1)) begin
                  next_phase = (instr == OP_READ || instr == OP_WRITE) ? SECP_PH_DATA : SECP_PH_IDLE;
                  next_byteDone = 1'b1;
               end
            end
            SECP_PH_DATA: begin
               next_byteDone = 1'b1;
               next_byteCnt = byteCnt + 9'h1;
               if (byteCnt == 9'h0) begin
                  next_firstData = {shiftReg[6:0], serialIn};
               end
               if (instr == OP_READ) begin
                  next_addrReg = addrReg + 1'b1;
               end
            end
            default: next_byteDone = 1'b1;
         endcase
      end
      // Read data loaded at the last edge of each byte for shifting out
      if (!paused && phase == SECP_PH_DATA && bitCnt == 3'h7 && instr == OP_READ) begin
         next_outByte = readBlocked ? 8'h00 : arrayRdData;
      end
      if (!paused && phase == SECP_PH_ADDR && bitCnt == 3'h7 && addrCnt == 2'(ADDR_BYTES - 1)
          && instr == OP_READ) begin
         next_outByte = readBlocked ? 8'h00 : arrayRdData;
      end
   end

   always_ff @(posedge linkClk or posedge selectN) begin
      if (selectN) begin
         phase <= SECP_PH_INSTR;
         shiftReg <= 8'h00;
         instr <= 8'h00;
         bitCnt <= 3'h0;
         addrCnt <= 2'h0;
         addrReg <= '0;
         outByte <= 8'h00;
         byteCnt <= 9'h000;
         firstData <= 8'h00;
         byteDone <= 1'b0;
      end else begin
         phase <= next_phase;
         shiftReg <= next_shiftReg;
         instr <= next_instr;
         bitCnt <= next_bitCnt;
         addrCnt <= next_addrCnt;
         addrReg <= next_addrReg;
         outByte <= next_outByte;
         byteCnt <= next_byteCnt;
         firstData <= next_firstData;
         byteDone <= next_byteDone;
      end
   end

   // Read address presented combinationally; array assumed to answer within half a link clock
   // Data phase looks one byte ahead so the next byte is ready at its load edge
   assign arrayAddr = (phase == SECP_PH_ADDR) ? ADDR_W'({addrReg, shiftReg[6:0], serialIn}) : addrReg + 1'b1;
   assign serialOut = outByte[7];
   assign serialOutEn = ~selectN & pauseN & (phase == SECP_PH_DATA)
                        & (instr == OP_READ || instr == STATUS_READ_CMD || instr == WAKE_AND_SIGNATURE_CMD);

   // ***************************************************
   // Frame end: command captured in link domain, handed by toggle
   // ***************************************************
   secp_cmd_t frameCmd;
   logic [7:0] frameInstr;
   logic frameWhole;
   logic frameToggle;
   always_comb begin
      frameCmd = '{job: SECP_OP_NONE, addr: addrReg, data: firstData, count: byteCnt};
      unique case (instr)
         OP_WRITE: frameCmd.job = SECP_OP_WRITE;
         STATUS_WRITE_CMD: frameCmd.job = SECP_OP_STATUS;
         PAGE_ERASE_CMD: frameCmd.job = SECP_OP_PAGE_ERASE;
         SECTOR_ERASE_CMD: frameCmd.job = SECP_OP_SECTOR_ERASE;
         CHIP_ERASE_CMD: frameCmd.job = SECP_OP_CHIP_ERASE;
         default: frameCmd.job = SECP_OP_NONE;
      endcase
   end

   // Latched on select rising; frame state is still intact at that edge
   // System reset clears the toggle so both domains start in agreement
   secp_cmd_t heldCmd;
   always_ff @(posedge selectN or posedge rst) begin
      if (rst) begin
         heldCmd <= '{job: SECP_OP_NONE, addr: '0, data: 8'h00, count: 9'h000};
         frameInstr <= 8'h00;
         frameWhole <= 1'b0;
         frameToggle <= 1'b0;
      end else begin
         heldCmd <= frameCmd;
         frameInstr <= instr;
         frameWhole <= byteDone & (bitCnt == 3'h0);
         frameToggle <= ~frameToggle;
      end
   end

   // ***************************************************
   // System domain
   // ***************************************************
   logic [2:0] togSync;
   logic togSeen;
   logic frameEvt;
   always_ff @(posedge clk) begin
      togSync <= {togSync[1:0], frameToggle};
      if (rst) begin
         togSeen <= 1'b0;
      end else if (togSync[2] == togSync[1]) begin
         togSeen <= togSync[2];
      end
   end
   assign frameEvt = (togSync[2] == togSync[1]) && (togSync[2] != togSeen);

   typedef enum logic [1:0] {
      SECP_SY_IDLE = 2'b00,
      SECP_SY_BUSY = 2'b01,
      SECP_SY_SLEEPING = 2'b10,
      SECP_SY_WAKING = 2'b11
   } secp_sys_t;

   secp_sys_t sysState, next_sysState;
   logic [CNT_W-1:0] timer, next_timer;
   logic latch, next_latch;
   logic [7:0] statusReg, next_statusReg;
   logic sleepPend, next_sleepPend;
   logic [ADDR_W-1:0] next_memAddr;
   logic [7:0] next_memData;
   logic next_memWrite;
   secp_job_t next_memJob;

   always_comb begin
      next_sysState = sysState;
      next_timer = (timer != '0) ? timer - 1'b1 : timer;
      next_latch = latch;
      next_statusReg = statusReg;
      next_sleepPend = sleepPend;
      next_memAddr = memAddr;
      next_memData = memData;
      next_memWrite = 1'b0;
      next_memJob = memJob;
      unique case (sysState)
         SECP_SY_IDLE: begin
            if (frameEvt && frameWhole) begin
               if (frameInstr == SET_WRITE_LATCH_CMD) next_latch = 1'b1;
               if (frameInstr == CLEAR_WRITE_LATCH_CMD) next_latch = 1'b0;
               if (frameInstr == DEEP_SLEEP_CMD) begin
                  next_sysState = SECP_SY_SLEEPING;
                  next_timer = CNT_W'(SLEEP_CYC);
                  next_sleepPend = 1'b1;
               end
               if (latch && heldCmd.job != SECP_OP_NONE
                   && (heldCmd.count != 9'h0 || heldCmd.job != SECP_OP_WRITE)) begin
                  next_sysState = SECP_SY_BUSY;
                  next_memJob = heldCmd.job;
                  // Start address is passed on as captured; only the first byte is committed here
                  next_memAddr = heldCmd.addr;
                  next_memData = heldCmd.data;
                  next_memWrite = 1'b1;
                  if (heldCmd.job == SECP_OP_STATUS) next_statusReg = heldCmd.data;
                  next_timer = (heldCmd.job == SECP_OP_CHIP_ERASE || heldCmd.job == SECP_OP_SECTOR_ERASE)
                     ? CNT_W'(EraseCycles) : CNT_W'(WriteCycles);
               end
            end
         end
         SECP_SY_BUSY: begin
            if (timer == '0) begin
               next_sysState = SECP_SY_IDLE;
               next_latch = 1'b0;
               next_memJob = SECP_OP_NONE;
            end
         end
         SECP_SY_SLEEPING: begin
            if (timer == '0) next_sleepPend = 1'b0;
            if (frameEvt && frameInstr == WAKE_AND_SIGNATURE_CMD) begin
               next_sysState = SECP_SY_WAKING;
               next_timer = CNT_W'(WAKE_CYC);
            end
         end
         SECP_SY_WAKING: begin
            if (timer == '0) begin
               next_sysState = SECP_SY_IDLE;
               next_sleepPend = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sysState <= SECP_SY_IDLE;
         timer <= '0;
         latch <= 1'b0;
         statusReg <= STATUS_RESET;
         sleepPend <= 1'b0;
         memAddr <= '0;
         memData <= 8'h00;
         memWrite <= 1'b0;
         memJob <= SECP_OP_NONE;
      end else begin
         sysState <= next_sysState;
         timer <= next_timer;
         latch <= next_latch;
         statusReg <= next_statusReg;
         sleepPend <= next_sleepPend;
         memAddr <= next_memAddr;
         memData <= next_memData;
         memWrite <= next_memWrite;
         memJob <= next_memJob;
      end
   end

   assign busy = (sysState == SECP_SY_BUSY);
   assign writeLatch = latch;
   assign deepSleep = (sysState == SECP_SY_SLEEPING) && !sleepPend;

   // Status enters the link domain through three stages; a copy is taken once the last two agree
   // Link clock runs only in frames, so the copy may lag by a few bits
   logic [7:0] statusMeta, statusMid, statusLate;
   always_ff @(posedge linkClk) begin
      statusMeta <= {statusReg[7:2], latch, busy};
      statusMid <= statusMeta;
      statusLate <= statusMid;
      if (statusMid == statusLate) begin
         statusSync <= statusLate;
      end
   end
   assign readBlocked = statusSync[0];
endmodule // secp_port

// File: testbench/secp_host.sv
// Purpose: Host serial master model
// Assumes: 64 ns link clock, only inside frames
// Notes: Data changes while the clock is low
`timescale 1ns/10ps
module secp_host (
   output logic linkClk,
   output logic selectN,
   output logic serialIn,
   output logic pauseN,
   input wire logic serialOut
);
   // ****
   // Frame tasks
   // ****
   logic [7:0] rx;
   initial begin
      linkClk = 1'b0;
      serialIn = 1'b0;
      pauseN = 1'b1;
      // Select rising after time zero gives the frame logic a clean reset edge
      #1 selectN = 1'b1;
   end
   task automatic start();
      selectN = 1'b0;
      #40;
   endtask
   task automatic stop();
      #40;
      selectN = 1'b1;
      serialIn = ~serialIn; // Idle line must not repeat the last bit
      #200;
   endtask
   task automatic hold();
      pauseN = 1'b0;
      repeat (3) begin
         serialIn = ~serialIn; // Shared clock keeps running meanwhile
         #32 linkClk = 1'b1;
         #32 linkClk = 1'b0;
      end
      pauseN = 1'b1;
      #32;
   endtask
   task automatic xfer(input logic [7:0] tx, input int pauseAt);
      for (int i = 7; i >= 0; i--) begin
         if (i == pauseAt) hold();
         serialIn = tx[i];
         #32;
         rx[i] = serialOut;
         linkClk = 1'b1;
         #32;
         linkClk = 1'b0;
      end
   endtask
endmodule // secp_host

// File: testbench/secp_port_asserts.sv
// Purpose: Port checks for secp_port
// Assumes: Checks run on the system clock only
// Notes: Link activity is judged through selectN and pauseN
`timescale 1ns/10ps
module secp_port_asserts
   import secp_pkg::*;
#(
   parameter int EraseCycles = 50
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic linkClk,
   input wire logic selectN,
   input wire logic serialIn,
   input wire logic pauseN,
   input wire logic serialOut,
   input wire logic serialOutEn,
   input wire logic [ADDR_W-1:0] arrayAddr,
   input wire logic [7:0] arrayRdData,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic [7:0] memData,
   input wire logic memWrite,
   input wire secp_job_t memJob,
   input wire logic busy,
   input wire logic writeLatch,
   input wire logic deepSleep
);
   // ****
   // Checks
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [CNT_W-1:0] busyCnt;
   logic [CNT_W-1:0] next_busyCnt;
   always_comb begin
      next_busyCnt = busy ? busyCnt + 1'b1 : '0;
   end
   always_ff @(posedge clk) begin
      busyCnt <= rst ? '0 : next_busyCnt;
   end
   pulse_one_a: assert property (memWrite |=> !memWrite)
      else $error("memWrite held past one cycle");
   job_known_a: assert property (memWrite |-> memJob != SECP_OP_NONE)
      else $error("job issued with no kind");
   latch_needed_a: assert property (memWrite |-> $past(writeLatch))
      else $error("job issued without write latch");
   job_after_rise_a: assert property (memWrite |-> selectN && $past(selectN))
      else $error("job issued while selected");
   idle_before_job_a: assert property (memWrite |-> !$past(busy))
      else $error("job issued while busy");
   busy_bound_a: assert property (busy |-> busyCnt <= EraseCycles)
      else $error("self-timed cycle too long");
   quiet_deselect_a: assert property (selectN && $past(selectN) |-> !serialOutEn)
      else $error("output driven while deselected");
   quiet_pause_a: assert property (!pauseN && $past(!pauseN) |-> !serialOutEn)
      else $error("output driven while paused");
   sleep_on_rise_a: assert property ($rose(deepSleep) |-> selectN)
      else $error("deep sleep entered while selected");
endmodule // secp_port_asserts

bind secp_port secp_port_asserts #(.EraseCycles(EraseCycles)) u_chk (.clk(clk), .rst(rst),
   .linkClk(linkClk), .selectN(selectN), .serialIn(serialIn), .pauseN(pauseN),
   .serialOut(serialOut), .serialOutEn(serialOutEn), .arrayAddr(arrayAddr),
   .arrayRdData(arrayRdData), .memAddr(memAddr), .memData(memData), .memWrite(memWrite),
   .memJob(memJob), .busy(busy), .writeLatch(writeLatch), .deepSleep(deepSleep));

// File: testbench/testbench.sv
// Purpose: Self-checking bench for secp_port
// Assumes: Shortened self-timed cycles
// Notes: Array contents are a fixed function of address
`timescale 1ns/10ps
module testbench
   import secp_pkg::*;
();
   // ****
   // Bench
   // ****
   logic clk = 1'b0;
   logic rst;
   logic linkClk, selectN, serialIn, pauseN, serialOut, serialOutEn, memWrite, busy, writeLatch, deepSleep;
   logic [ADDR_W-1:0] arrayAddr, memAddr;
   logic [7:0] memData, arrayRdData;
   secp_job_t memJob;
   secp_cmd_t lastJob;
   logic [7:0] rb [6];
   int n_errors = 0;
   int compares = 0;
   int nJobs = 0;
   int cycles = 0;
   always #12.5 clk = ~clk;
   assign arrayRdData = {arrayAddr[16], arrayAddr[6:0]} ^ 8'h3C;
   secp_port #(.WriteCycles(50), .EraseCycles(60)) u_dut (.clk(clk), .rst(rst), .linkClk(linkClk),
      .selectN(selectN), .serialIn(serialIn), .pauseN(pauseN), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .arrayAddr(arrayAddr), .arrayRdData(arrayRdData), .memAddr(memAddr),
      .memData(memData), .memWrite(memWrite), .memJob(memJob), .busy(busy), .writeLatch(writeLatch),
      .deepSleep(deepSleep));
   secp_host host (.linkClk(linkClk), .selectN(selectN), .serialIn(serialIn), .pauseN(pauseN),
      .serialOut(serialOut));
   always @(posedge clk) begin
      cycles++;
      if (memWrite === 1'b1) begin
         nJobs++;
         lastJob = '{memJob, memAddr, memData, 9'h000};
      end
      if (cycles == 40000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic run(input logic [7:0] b0, b1, b2, b3, input int n, input int pAt);
      logic [7:0] fb [6];
      fb = '{b0, b1, b2, b3, 8'h00, 8'h00};
      host.start();
      for (int i = 0; i < n; i++) begin
         host.xfer(fb[i], (i == 2) ? pAt : -1);
         rb[i] = host.rx;
      end
      host.stop();
      repeat (12) @(posedge clk);
   endtask
   task automatic settle(input int lim, input logic lvl, input bit sleep);
      for (int k = 0; k < lim && (sleep ? deepSleep : busy) !== lvl; k++) @(posedge clk);
   endtask
   task automatic t_latch();
      check("writeLatch reset", 0, writeLatch);
      run(SET_WRITE_LATCH_CMD, OP_WRITE, 8'h00, 8'h00, 5, -1);
      check("write in latch frame", 0, nJobs);
      run(8'hFF, 8'h00, 8'h00, 8'h00, 1, -1);
      check("unknown code", 0, nJobs);
      run(CLEAR_WRITE_LATCH_CMD, 8'h00, 8'h00, 8'h00, 1, -1);
      check("writeLatch pre-clear", 0, writeLatch);
      run(SET_WRITE_LATCH_CMD, 8'h00, 8'h00, 8'h00, 1, -1);
      check("writeLatch set", 1, writeLatch);
      run(CLEAR_WRITE_LATCH_CMD, 8'h00, 8'h00, 8'h00, 1, -1);
      check("writeLatch clear", 0, writeLatch);
      run(OP_WRITE, 8'h01, 8'h23, 8'h45, 5, -1);
      check("write no latch", 0, nJobs);
   endtask
   task automatic t_write();
      run(SET_WRITE_LATCH_CMD, 8'h00, 8'h00, 8'h00, 1, -1);
      host.start();
      host.xfer(OP_WRITE, -1);
      host.xfer(8'h01, -1);
      host.xfer(8'h23, 3);
      host.xfer(8'h45, -1);
      host.xfer(8'h3C, -1);
      host.stop();
      repeat (12) @(posedge clk);
      check("write kind", SECP_OP_WRITE, lastJob.job);
      check("write addr", 17'h12345, lastJob.addr);
      check("write data", 8'h3C, lastJob.data);
      check("write busy", 1, busy);
      run(STATUS_READ_CMD, 8'h00, 8'h00, 8'h00, 2, -1);
      check("status in write", 8'h03, rb[1]);
      settle(60, 1'b0, 1'b0);
      check("write busy end", 0, busy);
      check("latch after write", 0, writeLatch);
   endtask
   task automatic t_erase();
      secp_job_t kinds [3] = '{SECP_OP_PAGE_ERASE, SECP_OP_SECTOR_ERASE, SECP_OP_CHIP_ERASE};
      logic [7:0] ops [3] = '{PAGE_ERASE_CMD, SECTOR_ERASE_CMD, CHIP_ERASE_CMD};
      for (int i = 0; i < 3; i++) begin
         run(SET_WRITE_LATCH_CMD, 8'h00, 8'h00, 8'h00, 1, -1);
         run(ops[i], 8'h01, 8'h00, 8'h00, (i == 2) ? 1 : 4, -1);
         check("erase kind", kinds[i], lastJob.job);
         settle(70, 1'b0, 1'b0);
         check("erase busy end", 0, busy);
      end
   endtask
   task automatic t_status();
      run(SET_WRITE_LATCH_CMD, 8'h00, 8'h00, 8'h00, 1, -1);
      run(STATUS_WRITE_CMD, 8'h0C, 8'h00, 8'h00, 2, -1);
      check("status kind", SECP_OP_STATUS, lastJob.job);
      check("status data", 8'h0C, lastJob.data);
      settle(70, 1'b0, 1'b0);
      run(STATUS_READ_CMD, 8'h00, 8'h00, 8'h00, 2, -1);
      check("status read", 8'h0C, rb[1]);
   endtask
   task automatic t_read();
      run(OP_READ, 8'h01, 8'hFF, 8'hFF, 6, -1);
      check("read top", 8'hC3, rb[4]);
      check("read wrap", 8'h3C, rb[5]);
   endtask
   task automatic t_sleep();
      run(DEEP_SLEEP_CMD, 8'h00, 8'h00, 8'h00, 1, -1);
      settle(SLEEP_CYC, 1'b1, 1'b1);
      check("deepSleep on", 1, deepSleep);
      run(WAKE_AND_SIGNATURE_CMD, 8'h00, 8'h00, 8'h00, 5, -1);
      check("signature", 8'h5A, rb[1]);
      settle(WAKE_CYC, 1'b0, 1'b1);
      check("deepSleep off", 0, deepSleep);
   endtask
   task automatic close_out();
      $display("errors %0d, compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_latch();
      t_write();
      t_erase();
      t_status();
      t_read();
      t_sleep();
      close_out();
   end
endmodule // testbench
